// File: logic/iofm_params.svh
// Constants for the connector pin function assignment block.
`ifndef IOFM_PARAMS_SVH
`define IOFM_PARAMS_SVH
`define IOFM_NUM_GIN 9
`define IOFM_NUM_GOUT 4
`define IOFM_NUM_IFN 20
`define IOFM_NUM_OFN 9
`define IOFM_PIN_W 4
`define IOFM_PIN_NONE 4'h0
`define IOFM_LVL_OPEN 1'b0
`define IOFM_RATE_W 3
`define IOFM_DIV_W 14
`define IOFM_CLK_HZ 125000000
`define IOFM_BPS_9600 9600
`define IOFM_BPS_19200 19200
`define IOFM_BPS_38400 38400
`define IOFM_BPS_57600 57600
`define IOFM_BPS_115200 115200
`define IOFM_FRAME_DATA_BITS 8
`define IOFM_FRAME_STOP_BITS 1
`endif

// File: logic/iofm_pin_mux.sv
// Connector pin function assignment with staged, stored and active settings.
//
// Operation
// - Factory state: no functions, plain inputs/outputs.
// - Each input function selects its own input pin.
// - Level bit: 0 normally open, 1 inverts.
// - Both travel limits share one level setting.
// - Output functions assignable; brake release has no level.
// - Store command saves; settings act after a restart command.
// - Link rate defaults 9600; both ends must match.
// - Link framing 8N1 at five listed rates.
// - Unassigned inputs stay readable as general inputs.
`timescale 1ns/100ps
`include "iofm_params.svh"
module iofm_pin_mux (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Connector pins.
  input wire logic [`IOFM_NUM_GIN-1:0] general_input,
  output logic [`IOFM_NUM_GOUT-1:0] general_output,
  // Setting writes, staged until stored and then until the next restart.
  input wire logic cfg_wr,
  input wire logic cfg_is_output,
  input wire logic [4:0] cfg_index,
  input wire logic [`IOFM_PIN_W-1:0] cfg_pin,
  input wire logic cfg_level,
  input wire logic cfg_rate_wr,
  input wire iofm_pkg::iofm_rate_t link_rate_setting,
  input wire logic store_settings_cmd,
  input wire logic restart_cmd,
  input wire logic factory_reset_cmd,
  // Internal function states from the controller core.
  input wire logic [`IOFM_NUM_OFN-1:0] out_fn_state,
  input wire logic [`IOFM_NUM_GOUT-1:0] general_out_req,
  // Decoded input functions, active high.
  output logic [`IOFM_NUM_IFN-1:0] in_fn_active,
  output logic [`IOFM_NUM_IFN-1:0] in_fn_rise,
  // General input readback.
  output logic [`IOFM_NUM_GIN-1:0] general_in_state,
  output logic [`IOFM_NUM_GIN-1:0] general_in_free,
  // Active link rate.
  output iofm_pkg::iofm_rate_t link_rate_active,
  output logic [`IOFM_DIV_W-1:0] link_bit_divisor
);
  import iofm_pkg::*;

  localparam int NI = `IOFM_NUM_IFN;
  localparam int NO = `IOFM_NUM_OFN;
  localparam int NG = `IOFM_NUM_GIN;
  localparam int NQ = `IOFM_NUM_GOUT;
  localparam logic [4:0] POS_LIM = 5'(IOFM_IN_POS_LIMIT);
  localparam logic [4:0] NEG_LIM = 5'(IOFM_IN_NEG_LIMIT);
  localparam logic [4:0] BRAKE = 5'(IOFM_OUT_BRAKE_RELEASE);

  ////////////////////////////////////////////////////////////////////////////////
  // Three copies of every setting: staged by writes, stored by the save command,
  // and active, which is the only copy the pin logic looks at.

  logic [`IOFM_PIN_W-1:0] stg_in_pin [NI];
  logic [`IOFM_PIN_W-1:0] sav_in_pin [NI];
  logic [`IOFM_PIN_W-1:0] act_in_pin [NI];
  logic [NI-1:0] stg_in_lvl;
  logic [NI-1:0] sav_in_lvl;
  logic [NI-1:0] act_in_lvl;
  logic [`IOFM_PIN_W-1:0] stg_out_pin [NO];
  logic [`IOFM_PIN_W-1:0] sav_out_pin [NO];
  logic [`IOFM_PIN_W-1:0] act_out_pin [NO];
  logic [NO-1:0] stg_out_lvl;
  logic [NO-1:0] sav_out_lvl;
  logic [NO-1:0] act_out_lvl;
  iofm_rate_t stg_rate;
  iofm_rate_t sav_rate;
  logic load_pending;

  // A restart copies the stored settings into the active set on the edge that samples it.
  wire apply_now = load_pending | restart_cmd;
  wire wr_in = cfg_wr & ~cfg_is_output & (cfg_index < 5'(NI));
  wire wr_out = cfg_wr & cfg_is_output & (cfg_index < 5'(NO));
  // Writing either travel limit level writes the single shared bit.
  wire [4:0] in_lvl_index = (cfg_index == NEG_LIM) ? POS_LIM : cfg_index;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_pending <= 1'b1;
    end else begin
      load_pending <= 1'b0;
    end
  end

  generate
    for (genvar f = 0; f < NI; f++) begin : g_in_cfg
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          stg_in_pin[f] <= `IOFM_PIN_NONE;
          sav_in_pin[f] <= `IOFM_PIN_NONE;
          act_in_pin[f] <= `IOFM_PIN_NONE;
          stg_in_lvl[f] <= `IOFM_LVL_OPEN;
          sav_in_lvl[f] <= `IOFM_LVL_OPEN;
          act_in_lvl[f] <= `IOFM_LVL_OPEN;
        end else begin
          if (factory_reset_cmd) begin
            stg_in_pin[f] <= `IOFM_PIN_NONE;
            sav_in_pin[f] <= `IOFM_PIN_NONE;
            stg_in_lvl[f] <= `IOFM_LVL_OPEN;
            sav_in_lvl[f] <= `IOFM_LVL_OPEN;
          end else begin
            if (wr_in && cfg_index == 5'(f)) begin
              stg_in_pin[f] <= (cfg_pin > 4'(NG)) ? `IOFM_PIN_NONE : cfg_pin;
            end
            if (wr_in && in_lvl_index == 5'(f)) begin
              stg_in_lvl[f] <= cfg_level;
            end
            if (store_settings_cmd) begin
              sav_in_pin[f] <= stg_in_pin[f];
              sav_in_lvl[f] <= stg_in_lvl[f];
            end
          end
          if (apply_now) begin
            act_in_pin[f] <= sav_in_pin[f];
            act_in_lvl[f] <= sav_in_lvl[f];
          end
        end
      end
    end

    for (genvar o = 0; o < NO; o++) begin : g_out_cfg
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          stg_out_pin[o] <= `IOFM_PIN_NONE;
          sav_out_pin[o] <= `IOFM_PIN_NONE;
          act_out_pin[o] <= `IOFM_PIN_NONE;
          stg_out_lvl[o] <= `IOFM_LVL_OPEN;
          sav_out_lvl[o] <= `IOFM_LVL_OPEN;
          act_out_lvl[o] <= `IOFM_LVL_OPEN;
        end else begin
          if (factory_reset_cmd) begin
            stg_out_pin[o] <= `IOFM_PIN_NONE;
            sav_out_pin[o] <= `IOFM_PIN_NONE;
            stg_out_lvl[o] <= `IOFM_LVL_OPEN;
            sav_out_lvl[o] <= `IOFM_LVL_OPEN;
          end else begin
            if (wr_out && cfg_index == 5'(o)) begin
              stg_out_pin[o] <= (cfg_pin > 4'(NQ)) ? `IOFM_PIN_NONE : cfg_pin;
              // The brake release output never takes a level setting.
              stg_out_lvl[o] <= (5'(o) == BRAKE) ? `IOFM_LVL_OPEN : cfg_level;
            end
            if (store_settings_cmd) begin
              sav_out_pin[o] <= stg_out_pin[o];
              sav_out_lvl[o] <= stg_out_lvl[o];
            end
          end
          if (apply_now) begin
            act_out_pin[o] <= sav_out_pin[o];
            act_out_lvl[o] <= sav_out_lvl[o];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Link rate: staged, stored and applied like the pin settings.

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stg_rate <= IOFM_RATE_9600;
      sav_rate <= IOFM_RATE_9600;
      link_rate_active <= IOFM_RATE_9600;
    end else begin
      if (factory_reset_cmd) begin
        stg_rate <= IOFM_RATE_9600;
        sav_rate <= IOFM_RATE_9600;
      end else begin
        if (cfg_rate_wr) begin
          stg_rate <= link_rate_setting;
        end
        if (store_settings_cmd) begin
          sav_rate <= stg_rate;
        end
      end
      if (apply_now) begin
        link_rate_active <= sav_rate;
      end
    end
  end

  // Bit period in core clocks for the stored rate, loaded with it on apply; the framing is 8N1.
  wire [31:0] next_div_wide = (sav_rate == IOFM_RATE_115200) ? 32'(`IOFM_CLK_HZ / `IOFM_BPS_115200) :
                              (sav_rate == IOFM_RATE_57600) ? 32'(`IOFM_CLK_HZ / `IOFM_BPS_57600) :
                              (sav_rate == IOFM_RATE_38400) ? 32'(`IOFM_CLK_HZ / `IOFM_BPS_38400) :
                              (sav_rate == IOFM_RATE_19200) ? 32'(`IOFM_CLK_HZ / `IOFM_BPS_19200) :
                              32'(`IOFM_CLK_HZ / `IOFM_BPS_9600);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_bit_divisor <= `IOFM_DIV_W'(`IOFM_CLK_HZ / `IOFM_BPS_9600);
    end else if (apply_now) begin
      link_bit_divisor <= next_div_wide[`IOFM_DIV_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Input functions: select pin, apply level, then detect the leading edge.

  logic [NI-1:0] next_fn_active;
  logic [NG-1:0] next_claimed;

  generate
    for (genvar f = 0; f < NI; f++) begin : g_in_fn
      wire assigned = (act_in_pin[f] != `IOFM_PIN_NONE);
      wire [3:0] sel = act_in_pin[f] - 4'h1;
      wire raw = assigned ? general_input[sel] : 1'b0;
      // The limit pair reads the shared level bit held at the positive slot.
      wire lvl = (5'(f) == NEG_LIM) ? act_in_lvl[POS_LIM] : act_in_lvl[f];
      assign next_fn_active[f] = assigned & (raw ^ lvl);
    end
    for (genvar g = 0; g < NG; g++) begin : g_claim
      logic hit;
      always_comb begin
        hit = 1'b0;
        for (int f = 0; f < NI; f++) begin
          hit = hit | (act_in_pin[f] == 4'(g + 1));
        end
      end
      assign next_claimed[g] = hit;
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_fn_active <= '0;
      in_fn_rise <= '0;
      general_in_state <= '0;
      general_in_free <= '1;
    end else begin
      in_fn_active <= next_fn_active;
      in_fn_rise <= next_fn_active & ~in_fn_active;
      general_in_state <= general_input;
      general_in_free <= ~next_claimed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output pins: an assigned function wins, else the general request drives it.
  // Should two functions claim one pin, the higher-numbered function wins.

  logic [NQ-1:0] next_out;

  generate
    for (genvar q = 0; q < NQ; q++) begin : g_out_pin
      logic v;
      always_comb begin
        v = general_out_req[q];
        for (int o = 0; o < NO; o++) begin
          if (act_out_pin[o] == 4'(q + 1)) begin
            v = out_fn_state[o] ^ act_out_lvl[o];
          end
        end
      end
      assign next_out[q] = v;
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      general_output <= '0;
    end else begin
      general_output <= next_out;
    end
  end
endmodule : iofm_pin_mux

// File: logic/iofm_pkg.sv
// Types for the connector pin function assignment block.
package iofm_pkg;
  typedef enum logic [4:0] {
    IOFM_IN_PANIC_HALT, IOFM_IN_MOTION_HALT, IOFM_IN_PAUSE, IOFM_IN_PAUSE_CANCEL,
    IOFM_IN_RESUME, IOFM_IN_FAULT_CLEAR, IOFM_IN_SENSOR, IOFM_IN_HOME,
    IOFM_IN_POS_LIMIT, IOFM_IN_NEG_LIMIT, IOFM_IN_ABORT, IOFM_IN_START,
    IOFM_IN_JOG_POS, IOFM_IN_JOG_NEG, IOFM_IN_SEEK_POS, IOFM_IN_SEEK_NEG,
    IOFM_IN_ENERGIZE, IOFM_IN_SHAFT_FREE, IOFM_IN_FOLLOW_ERR_CLEAR, IOFM_IN_TORQUE_LIMIT
  } iofm_in_fn_t;
  typedef enum logic [3:0] {
    IOFM_OUT_ALARM, IOFM_OUT_MOTION_END, IOFM_OUT_SEQ_RUN, IOFM_OUT_MOVING,
    IOFM_OUT_READY, IOFM_OUT_LIMITING, IOFM_OUT_PAUSED, IOFM_OUT_AT_ORIGIN,
    IOFM_OUT_BRAKE_RELEASE
  } iofm_out_fn_t;
  typedef enum logic [2:0] {
    IOFM_RATE_9600, IOFM_RATE_19200, IOFM_RATE_38400, IOFM_RATE_57600, IOFM_RATE_115200
  } iofm_rate_t;
endpackage : iofm_pkg

// File: tb/iofm_field_model.sv
// Switches and sensors wired to the connector, with loads on the outputs.
`timescale 1ns/100ps
module iofm_field_model (
  // Actuator states and wiring.
  input wire logic [8:0] pressed,
  input wire logic [8:0] nc_wired,
  // Connector.
  output logic [8:0] general_input,
  input wire logic [3:0] general_output
);
  // A normally closed contact conducts while its actuator is released.
  assign general_input = pressed ^ nc_wired;
endmodule : iofm_field_model

// File: tb/iofm_pin_mux_monitor.sv
// Assertions on the ports of the pin function assignment block.
`timescale 1ns/100ps
module iofm_pin_mux_monitor (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Watched ports.
  input wire logic [8:0] general_input,
  input wire logic restart_cmd,
  input wire logic [19:0] in_fn_active,
  input wire logic [19:0] in_fn_rise,
  input wire logic [8:0] general_in_state,
  input wire logic [8:0] general_in_free,
  input wire iofm_pkg::iofm_rate_t link_rate_active,
  input wire logic [13:0] link_bit_divisor
);
  import iofm_pkg::*;
  localparam int BPS [5] = '{9600, 19200, 38400, 57600, 115200};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_quiet;
    (rst_n && !restart_cmd) [*3];
  endsequence
  property p_rise_edge;
    $past(rst_n) |-> in_fn_rise == (in_fn_active & ~$past(in_fn_active));
  endproperty
  a_rise_edge: assert property (p_rise_edge) else $error("rise pulse off edge");
  property p_in_copy;
    $past(rst_n) |-> general_in_state == $past(general_input);
  endproperty
  a_in_copy: assert property (p_in_copy) else $error("input readback wrong");
  property p_reset_vals;
    $rose(rst_n) |-> &general_in_free && in_fn_active == '0 && link_rate_active == IOFM_RATE_9600
      && link_bit_divisor == 14'h32dc;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset state wrong");
  property p_div_match;
    $past(rst_n) && $stable(link_rate_active) |-> 32'(link_bit_divisor) == 125000000 / BPS[link_rate_active];
  endproperty
  a_div_match: assert property (p_div_match) else $error("divisor wrong");
  property p_rate_hold;
    s_quiet |=> $stable(link_rate_active);
  endproperty
  a_rate_hold: assert property (p_rate_hold) else $error("rate moved without restart");
  property p_free_hold;
    s_quiet |=> $stable(general_in_free);
  endproperty
  a_free_hold: assert property (p_free_hold) else $error("free map moved without restart");
  property p_fn_hold;
    (rst_n && !restart_cmd && $stable(general_input)) [*3] |=> $stable(in_fn_active);
  endproperty
  a_fn_hold: assert property (p_fn_hold) else $error("function moved on still pins");
  property p_free_empty;
    $past(&general_in_free) && &general_in_free |-> in_fn_active == '0;
  endproperty
  a_free_empty: assert property (p_free_empty) else $error("unassigned function active");
endmodule : iofm_pin_mux_monitor
bind iofm_pin_mux iofm_pin_mux_monitor i_mon (.core_clk(core_clk), .rst_n(rst_n), .general_input(general_input),
  .restart_cmd(restart_cmd), .in_fn_active(in_fn_active), .in_fn_rise(in_fn_rise), .general_in_state(general_in_state),
  .general_in_free(general_in_free), .link_rate_active(link_rate_active), .link_bit_divisor(link_bit_divisor));

// File: tb/testbench.sv
// Self-checking bench for the pin function assignment block.
`timescale 1ns/100ps
module testbench;
  import iofm_pkg::*;
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
  localparam int BPS [5] = '{9600, 19200, 38400, 57600, 115200};
  logic core_clk = 1'b0, rst_n = 1'b0, wr = 1'b0, is_o = 1'b0, lvl = 1'b0;
  logic rwr = 1'b0, sto = 1'b0, rst_c = 1'b0, fac = 1'b0;
  logic [4:0] idx = 5'h0;
  logic [3:0] pin = 4'h0, req = 4'h0, gout;
  logic [8:0] pr = 9'h0, nc = 9'h0, fs = 9'h0, gin, gst, gfree;
  logic [19:0] act, rise, prev = 20'h0;
  iofm_rate_t rset = IOFM_RATE_9600, ract, host_rate = IOFM_RATE_9600;
  logic [13:0] div;
  logic [4:0] icf [3][20];
  logic [4:0] ocf [3][9];
  iofm_rate_t rcf [3];
  int miscompares = 0, total_checks = 0;
  always #4 core_clk = ~core_clk;
  iofm_pin_mux i_dut (.core_clk(core_clk), .rst_n(rst_n), .general_input(gin), .general_output(gout), .cfg_wr(wr),
    .cfg_is_output(is_o), .cfg_index(idx), .cfg_pin(pin), .cfg_level(lvl), .cfg_rate_wr(rwr), .link_rate_setting(rset),
    .store_settings_cmd(sto), .restart_cmd(rst_c), .factory_reset_cmd(fac), .out_fn_state(fs), .general_out_req(req),
    .in_fn_active(act), .in_fn_rise(rise), .general_in_state(gst), .general_in_free(gfree), .link_rate_active(ract),
    .link_bit_divisor(div));
  iofm_field_model i_field (.pressed(pr), .nc_wired(nc), .general_input(gin), .general_output(gout));
  ////////////////////////////////////////////////////////////
  function automatic logic [19:0] exp_in();
    exp_in = 20'h0;
    for (int i = 0; i < 20; i++)
      if (icf[2][i][3:0] != 4'h0) exp_in[i] = gin[icf[2][i][3:0] - 1] ^ icf[2][i == 9 ? 8 : i][4];
  endfunction : exp_in
  function automatic logic [8:0] exp_free();
    exp_free = 9'h1ff;
    for (int i = 0; i < 20; i++) if (icf[2][i][3:0] != 4'h0) exp_free[icf[2][i][3:0] - 1] = 1'b0;
  endfunction : exp_free
  function automatic logic [3:0] exp_out();
    exp_out = req;
    for (int j = 0; j < 9; j++) if (ocf[2][j][3:0] != 4'h0) exp_out[ocf[2][j][3:0] - 1] = fs[j] ^ ocf[2][j][4];
  endfunction : exp_out
  task automatic cfg(input logic o, input logic [4:0] x, input logic [3:0] p, input logic l);
    @(posedge core_clk);
    {wr, is_o, idx, pin, lvl} <= {1'b1, o, x, p, l};
    @(posedge core_clk);
    wr <= 1'b0;
    if (p > (o ? 4'h4 : 4'h9)) p = 4'h0;
    if (o && x < 9) ocf[0][x] = {l && x != 8, p};
    if (!o && x < 20) begin
      icf[0][x][3:0] = p;
      icf[0][x == 9 ? 5'h8 : x][4] = l;
    end
  endtask : cfg
  task automatic cmd(input logic [3:0] c);
    @(posedge core_clk);
    {rwr, sto, rst_c, fac} <= c;
    @(posedge core_clk);
    {rwr, sto, rst_c, fac} <= 4'h0;
    if (c[1]) begin
      icf[2] = icf[1];
      ocf[2] = ocf[1];
      rcf[2] = rcf[1];
    end
    if (c[3]) rcf[0] = rset;
    for (int k = 0; k < 2; k++) begin
      if (c[0]) icf[k] = '{default: 5'h0};
      if (c[0]) ocf[k] = '{default: 5'h0};
      if (c[0]) rcf[k] = IOFM_RATE_9600;
    end
    if (c[2] && !c[0]) begin
      icf[1] = icf[0];
      ocf[1] = ocf[0];
      rcf[1] = rcf[0];
    end
    repeat (2) @(posedge core_clk);
    prev = exp_in();
  endtask : cmd
  task automatic step();
    @(posedge core_clk);
    {pr, fs, req} <= 22'($urandom());
    @(posedge core_clk);
    #1;
    `CHK("in_fn_active", exp_in(), act)
    `CHK("in_fn_rise", exp_in() & ~prev, rise)
    `CHK("general_in_state", gin, gst)
    `CHK("general_in_free", exp_free(), gfree)
    `CHK("general_output", exp_out(), gout)
    `CHK("link_rate_active", rcf[2], ract)
    `CHK("link_bit_divisor", 14'(125000000 / BPS[rcf[2]]), div)
    prev = exp_in();
  endtask : step
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    close_out();
  end
  initial begin
    icf = '{default: 5'h0};
    ocf = '{default: 5'h0};
    rcf = '{default: IOFM_RATE_9600};
    void'($urandom(32'h4368));
    nc = 9'($urandom());
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) step();
    $display("factory state test done");
    cfg(1'b0, 5'h0, 4'h3, 1'b1);
    cfg(1'b1, 5'h8, 4'h4, 1'b1);
    cmd(4'h6);
    step();
    cmd(4'h2);
    repeat (2) step();
    $display("staged settings test done");
    for (int r = 0; r < 6; r++) begin
      repeat (12) cfg(1'($urandom()), 5'($urandom()), 4'($urandom()), 1'($urandom()));
      cmd(4'h4);
      step();
      cmd(4'h2);
      repeat (8) step();
    end
    $display("random assignment test done");
    for (int r = 0; r < 5; r++) begin
      @(posedge core_clk);
      rset <= iofm_rate_t'(r);
      cmd(4'h8);
      cmd(4'h4);
      cmd(4'h2);
      step();
      // The host switches its own port only after the device has taken the new rate.
      host_rate = rset;
      `CHK("host link rate", host_rate, ract)
    end
    `CHK("preferred link rate", IOFM_RATE_115200, ract)
    $display("link rate test done");
    cmd(4'h5);
    cmd(4'h2);
    repeat (2) step();
    $display("factory restore test done");
    close_out();
  end
endmodule : testbench
